// ---- common/frc_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef FRC_MAP_SVH
`define FRC_MAP_SVH

// Register indices; byte address is four times the index
`define FRC_IDX_RATE_CFG     12'h3F7
`define FRC_IDX_RATE_STAT    12'h3F4
`define FRC_IDX_DATA         12'h3F5
`define FRC_IDX_OUT_CTL      12'h3F2
`define FRC_IDX_MODE_CFG     12'h3F0
`define FRC_IDX_STAT0        12'h3E0
`define FRC_IDX_STAT1        12'h3E1
`define FRC_IDX_IRQ_STAT     12'h3E4
`define FRC_IDX_IRQ_MASK     12'h3E5

// Rate select field and its reset (250 Kbps)
`define FRC_RATE_LSB         0
`define FRC_RATE_MSB         1
`define FRC_RATE_RESET       2'h2
`define FRC_RATE_500K        2'h0
`define FRC_RATE_300K        2'h1
`define FRC_RATE_250K        2'h2
`define FRC_RATE_1M          2'h3
`define FRC_PRECOMP_BIT      2
`define FRC_SWRST_BIT        7
`define FRC_CORE_RUN_BIT     2
`define FRC_MODE_LSB         2
`define FRC_MODE_MSB         3

// Status byte 0 fields
`define FRC_ST0_CODE_MSB     7
`define FRC_ST0_CODE_LSB     6
`define FRC_ST0_SEEK         5
`define FRC_ST0_FAULT        4
`define FRC_ST0_HEAD         2

// Status byte 1 fields
`define FRC_ST1_TRACK_END    7
`define FRC_ST1_CRC          5
`define FRC_ST1_OVERRUN      4
`define FRC_ST1_NO_DATA      2
`define FRC_ST1_WPROT        1
`define FRC_ST1_NO_MARK      0

// Interrupt status bits
`define FRC_IRQ_RESULT       0
`define FRC_IRQ_SEEK         1
`define FRC_IRQ_FAULT        2
`define FRC_IRQ_W            3

// Completion codes
`define FRC_CODE_NORMAL      2'h0
`define FRC_CODE_FAILED      2'h1
`define FRC_CODE_INVALID     2'h2
`define FRC_CODE_POLLING     2'h3

// Search limits
`define FRC_RECAL_STEPS      80
`define FRC_INDEX_LIMIT      2

`endif

// ---- common/frc_pkg.sv ----
// Types shared by the rate control and result status block
`default_nettype none
package frc_pkg;

   typedef enum logic [1:0] {
      FRC_MODE_AT    = 2'h3,
      FRC_MODE_LATER = 2'h2,
      FRC_MODE_THIRD = 2'h0
   } frc_mode_t;

   typedef enum logic [2:0] {
      FRC_CMD_OTHER   = 3'h0,
      FRC_CMD_SEEK    = 3'h1,
      FRC_CMD_REL     = 3'h2,
      FRC_CMD_RECAL   = 3'h3,
      FRC_CMD_RD_DATA = 3'h4,
      FRC_CMD_WR_DATA = 3'h5,
      FRC_CMD_FORMAT  = 3'h6,
      FRC_CMD_READ_ID = 3'h7
   } frc_cmd_t;

   // Result phase sequencing, Gray along idle-exec-result
   typedef enum logic [1:0] {
      FRC_PH_IDLE   = 2'h0,
      FRC_PH_EXEC   = 2'h1,
      FRC_PH_RESULT = 2'h3
   } frc_phase_t;

   // Command start descriptor from the command engine
   typedef struct packed {
      frc_cmd_t   cmd;
      logic       head;
      logic [1:0] drive;
   } frc_start_t;

   // One-cycle event pulses from the execution engine
   typedef struct packed {
      logic sector_past_end;
      logic crc_fault;
      logic overrun;
      logic sector_missing;
      logic sector_seq_bad;
      logic data_mark_missing;
      logic step_outward_past_zero;
      logic step_pulse;
   } frc_evt_t;

endpackage
`default_nettype wire

// ---- src/frc_top.sv ----
// Rate configuration, density pin and result status bytes with AHB-Lite
`default_nettype none
`include "frc_map.svh"

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Write-only rate register at index 3F7, rate field resets to 10.
// - Third mode stores precomp flag in bit 2, read on rate status bit 2.
// - Density pin high on hardware reset, untouched by software resets.
// - Result phase data reads return the status bytes of last command.
// - Status 0 bits 7:6 hold completion code 00,01,10,11.
// - Status 0 bit 5 set when seek, relative seek or recalibrate ends.
// - Status 0 bit 4 on 80 steps without track zero or outward overstep.
// - Status 0 bit 3 zero, bit 2 head, bits 1:0 drive number.
// - Status 1 bit 7 on sector past end or data command without end.
// - Status 1 bit 5 set on ID or data field CRC failure.
// - Status 1 bit 4 set on overrun or underrun.
// - Status 1 bit 2 on missing sector, bad ID or wrong sequence.
// - Status 1 bit 1 when write protect high during write or format.
// - Status 1 bit 0: no ID mark in two index pulses, or no data mark.
// - Compatibility mode comes from the interface mode bits 3:2.
// - Rate bits survive software reset, hardware reset gives 250 Kbps.
module frc_top #(
   parameter int RECAL_STEPS = `FRC_RECAL_STEPS
) (
   // Clock and reset
   input  wire logic               MCLK_I,
   input  wire logic               RESET_N_I,
   // AHB-Lite slave
   input  wire logic               HSEL_I,
   input  wire logic [31:0]        HADDR_I,
   input  wire logic [1:0]         HTRANS_I,
   input  wire logic               HWRITE_I,
   input  wire logic [2:0]         HSIZE_I,
   input  wire logic [31:0]        HWDATA_I,
   input  wire logic               HREADY_I,
   output logic [31:0]             HRDATA_O,
   output logic                    HREADYOUT_O,
   output logic                    HRESP_O,
   // Command engine
   input  wire logic               CMD_START_I,
   input  wire frc_pkg::frc_start_t CMD_INFO_I,
   input  wire logic               CMD_END_I,
   input  wire logic [1:0]         CMD_CODE_I,
   input  wire frc_pkg::frc_evt_t  EVT_I,
   // Drive pins
   input  wire logic               TRACK_ZERO_PIN_I,
   input  wire logic               INDEX_PULSE_PIN_I,
   input  wire logic               WRITE_PROTECT_PIN_I,
   input  wire logic               TRANSFER_END_SIGNAL_I,
   // Outputs
   output logic                    DENSITY_SELECT_PIN_O,
   output logic [1:0]              RATE_SELECT_O,
   output logic                    CORE_RESET_O,
   output logic                    IRQ_O
);

   initial
      if (RECAL_STEPS < 1 || RECAL_STEPS > 255)
         $error("RECAL_STEPS out of range");

   //////////////////////////////////////////////////////////////////////////
   // Functions

   // Byte address of a register index
   function automatic logic [13:0] reg_addr(input logic [11:0] idx);
      reg_addr = {idx, 2'h0};
   endfunction

   // High density rates: 500 Kbps and 1 Mbps
   function automatic logic is_high_rate(input logic [1:0] r);
      is_high_rate = r == `FRC_RATE_500K || r == `FRC_RATE_1M;
   endfunction

   // Pin level for a rate in a given mode; active high only in AT mode
   function automatic logic density_level(input logic [1:0] r,
                                          input frc_pkg::frc_mode_t m);
      density_level = (m == frc_pkg::FRC_MODE_AT) ? is_high_rate(r)
                                                  : !is_high_rate(r);
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait state, reads registered in the address phase

   logic              dp_write, acc, acc_rd, acc_wr, rd_data;
   logic [13:0]       dp_addr, a_addr;
   logic              wr_rate, wr_rstat, wr_out, wr_mode, wr_istat, wr_imask;
   logic [31:0]       next_rdata;
   assign acc    = HSEL_I && HREADY_I && HTRANS_I[1];
   assign acc_rd = acc && !HWRITE_I;
   assign acc_wr = acc && HWRITE_I;
   assign a_addr = HADDR_I[13:0];
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O     = 1'b0;

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I) begin
         dp_write <= 1'b0;
         dp_addr  <= 14'h0000;
      end else begin
         dp_write <= acc_wr;
         dp_addr  <= a_addr;
      end
   end

   assign wr_rate  = dp_write && dp_addr == reg_addr(`FRC_IDX_RATE_CFG);
   assign wr_rstat = dp_write && dp_addr == reg_addr(`FRC_IDX_RATE_STAT);
   assign wr_out   = dp_write && dp_addr == reg_addr(`FRC_IDX_OUT_CTL);
   assign wr_mode  = dp_write && dp_addr == reg_addr(`FRC_IDX_MODE_CFG);
   assign wr_istat = dp_write && dp_addr == reg_addr(`FRC_IDX_IRQ_STAT);
   assign wr_imask = dp_write && dp_addr == reg_addr(`FRC_IDX_IRQ_MASK);
   assign rd_data  = acc_rd && a_addr == reg_addr(`FRC_IDX_DATA);

   //////////////////////////////////////////////////////////////////////////
   // Mode, rate, precompensation, density pin

   frc_pkg::frc_mode_t mode;
   logic [1:0]         rate, new_rate;
   logic               precomp_off_flag, density_select_pin;
   logic               core_run, sw_pulse, soft_rst;
   always_ff @(posedge MCLK_I)
      if (!RESET_N_I)
         mode <= frc_pkg::FRC_MODE_AT;
      else if (wr_mode)
         mode <= frc_pkg::frc_mode_t'(
                 HWDATA_I[`FRC_MODE_MSB:`FRC_MODE_LSB]);
   // Either register write sets the one rate state
   assign new_rate = HWDATA_I[`FRC_RATE_MSB:`FRC_RATE_LSB];
   always_ff @(posedge MCLK_I)
      if (!RESET_N_I)
         rate <= `FRC_RATE_RESET;
      else if (wr_rate || wr_rstat)
         rate <= new_rate;
   // Only the third mode stores the flag; no functional effect
   always_ff @(posedge MCLK_I)
      if (!RESET_N_I)
         precomp_off_flag <= 1'b0;
      else if (wr_rate && mode == frc_pkg::FRC_MODE_THIRD)
         precomp_off_flag <= HWDATA_I[`FRC_PRECOMP_BIT];
   // Driven high by hardware reset only; follows rate writes after that
   always_ff @(posedge MCLK_I)
      if (!RESET_N_I)
         density_select_pin <= 1'b1;
      else if (wr_rate || wr_rstat)
         density_select_pin <= density_level(new_rate, mode);
   // Output control reset is held by software; status reset self-clears
   always_ff @(posedge MCLK_I)
      if (!RESET_N_I)
         core_run <= 1'b0;
      else if (wr_out)
         core_run <= HWDATA_I[`FRC_CORE_RUN_BIT];
   always_ff @(posedge MCLK_I)
      if (!RESET_N_I)
         sw_pulse <= 1'b0;
      else
         sw_pulse <= wr_rstat && HWDATA_I[`FRC_SWRST_BIT];
   assign soft_rst = !core_run || sw_pulse;

   //////////////////////////////////////////////////////////////////////////
   // Command phase tracking

   frc_pkg::frc_phase_t phase;
   frc_pkg::frc_cmd_t   cmd;
   logic                res_ptr;

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I || soft_rst) begin
         phase   <= frc_pkg::FRC_PH_IDLE;
         res_ptr <= 1'b0;
      end else begin
         case (phase)
            frc_pkg::FRC_PH_IDLE:
               if (CMD_START_I)
                  phase <= frc_pkg::FRC_PH_EXEC;
            frc_pkg::FRC_PH_EXEC: begin
               if (CMD_END_I) begin
                  phase   <= frc_pkg::FRC_PH_RESULT;
                  res_ptr <= 1'b0;
               end
            end
            frc_pkg::FRC_PH_RESULT: begin
               if (rd_data) begin
                  res_ptr <= !res_ptr;
                  if (res_ptr) begin
                     phase <= frc_pkg::FRC_PH_IDLE;
                  end
               end else if (CMD_START_I) begin
                  phase <= frc_pkg::FRC_PH_EXEC;
               end
            end
            default:
               phase <= frc_pkg::FRC_PH_IDLE;
         endcase
      end
   end

   always_ff @(posedge MCLK_I)
      if (!RESET_N_I)
         cmd <= frc_pkg::FRC_CMD_OTHER;
      else if (CMD_START_I)
         cmd <= CMD_INFO_I.cmd;

   //////////////////////////////////////////////////////////////////////////
   // Search counters: recalibrate steps and index pulses

   logic       exec, index_d, index_rise, end_seen, wr_cmd;
   logic [7:0] step_cnt;
   logic [1:0] index_cnt;
   assign exec       = phase == frc_pkg::FRC_PH_EXEC;
   assign index_rise = INDEX_PULSE_PIN_I && !index_d;
   assign wr_cmd     = cmd == frc_pkg::FRC_CMD_WR_DATA ||
                       cmd == frc_pkg::FRC_CMD_FORMAT;
   always_ff @(posedge MCLK_I)
      if (!RESET_N_I)
         index_d <= 1'b0;
      else
         index_d <= INDEX_PULSE_PIN_I;
   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I || soft_rst || CMD_START_I) begin
         step_cnt  <= 8'h00;
         index_cnt <= 2'h0;
         end_seen  <= 1'b0;
      end else if (exec) begin
         if (EVT_I.step_pulse && cmd == frc_pkg::FRC_CMD_RECAL &&
             step_cnt != RECAL_STEPS[7:0])
            step_cnt <= step_cnt + 8'h01;
         if (index_rise && index_cnt != 2'(`FRC_INDEX_LIMIT))
            index_cnt <= index_cnt + 2'h1;
         if (TRANSFER_END_SIGNAL_I)
            end_seen <= 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Status bytes

   logic [1:0] code, drive;
   logic       head, seek_done_flag, equipment_fault_flag, track_end_flag;
   logic       crc_fault_flag, overrun_flag, sector_missing_flag;
   logic       write_protect_fault, mark_missing_flag;
   logic [7:0] stat0, stat1;
   logic       seek_cmd, data_cmd, fault_set;
   assign seek_cmd = cmd == frc_pkg::FRC_CMD_SEEK ||
                     cmd == frc_pkg::FRC_CMD_REL ||
                     cmd == frc_pkg::FRC_CMD_RECAL;
   assign data_cmd = cmd == frc_pkg::FRC_CMD_RD_DATA ||
                     cmd == frc_pkg::FRC_CMD_WR_DATA;
   assign fault_set = exec &&
      ((cmd == frc_pkg::FRC_CMD_RECAL && step_cnt == RECAL_STEPS[7:0] &&
        !TRACK_ZERO_PIN_I) ||
       (cmd == frc_pkg::FRC_CMD_REL && EVT_I.step_outward_past_zero));

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I || soft_rst) begin
         head  <= 1'b0;
         drive <= 2'h0;
         code  <= `FRC_CODE_NORMAL;
      end else if (CMD_START_I) begin
         head  <= CMD_INFO_I.head;
         drive <= CMD_INFO_I.drive;
      end else if (exec && CMD_END_I) begin
         code <= CMD_CODE_I;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I || soft_rst || CMD_START_I) begin
         seek_done_flag       <= 1'b0;
         equipment_fault_flag <= 1'b0;
      end else begin
         if (exec && CMD_END_I && seek_cmd)
            seek_done_flag <= 1'b1;
         if (fault_set)
            equipment_fault_flag <= 1'b1;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RESET_N_I || soft_rst || CMD_START_I) begin
         track_end_flag      <= 1'b0;
         crc_fault_flag      <= 1'b0;
         overrun_flag        <= 1'b0;
         sector_missing_flag <= 1'b0;
         write_protect_fault <= 1'b0;
         mark_missing_flag   <= 1'b0;
      end else if (exec) begin
         if (EVT_I.sector_past_end ||
             (CMD_END_I && data_cmd && !end_seen &&
              !TRANSFER_END_SIGNAL_I))
            track_end_flag <= 1'b1;
         if (EVT_I.crc_fault)
            crc_fault_flag <= 1'b1;
         if (EVT_I.overrun)
            overrun_flag <= 1'b1;
         if ((EVT_I.sector_missing &&
              cmd == frc_pkg::FRC_CMD_RD_DATA) ||
             (EVT_I.crc_fault && cmd == frc_pkg::FRC_CMD_READ_ID) ||
             EVT_I.sector_seq_bad)
            sector_missing_flag <= 1'b1;
         if (WRITE_PROTECT_PIN_I && wr_cmd)
            write_protect_fault <= 1'b1;
         if (index_cnt == 2'(`FRC_INDEX_LIMIT) ||
             EVT_I.data_mark_missing)
            mark_missing_flag <= 1'b1;
      end
   end

   always_comb begin
      stat0 = 8'h00;
      stat0[`FRC_ST0_CODE_MSB:`FRC_ST0_CODE_LSB] = code;
      stat0[`FRC_ST0_SEEK]  = seek_done_flag;
      stat0[`FRC_ST0_FAULT] = equipment_fault_flag;
      stat0[`FRC_ST0_HEAD]  = head;
      stat0[1:0]            = drive;
   end

   always_comb begin
      stat1 = 8'h00;
      stat1[`FRC_ST1_TRACK_END] = track_end_flag;
      stat1[`FRC_ST1_CRC]       = crc_fault_flag;
      stat1[`FRC_ST1_OVERRUN]   = overrun_flag;
      stat1[`FRC_ST1_NO_DATA]   = sector_missing_flag;
      stat1[`FRC_ST1_WPROT]     = write_protect_fault;
      stat1[`FRC_ST1_NO_MARK]   = mark_missing_flag;
   end

   //////////////////////////////////////////////////////////////////////////
   // Interrupts: sticky, write one to clear, set wins

   logic [`FRC_IRQ_W-1:0] irq_stat, irq_mask;
   logic [`FRC_IRQ_W-1:0] irq_set, irq_clr;
   assign irq_set = {fault_set,
                     exec && CMD_END_I && seek_cmd,
                     exec && CMD_END_I};
   assign irq_clr = wr_istat ? HWDATA_I[`FRC_IRQ_W-1:0]
                             : {`FRC_IRQ_W{1'b0}};

   always_ff @(posedge MCLK_I)
      if (!RESET_N_I)
         irq_stat <= {`FRC_IRQ_W{1'b0}};
      else
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
   always_ff @(posedge MCLK_I)
      if (!RESET_N_I)
         irq_mask <= {`FRC_IRQ_W{1'b0}};
      else if (wr_imask)
         irq_mask <= HWDATA_I[`FRC_IRQ_W-1:0];
   assign IRQ_O = |(irq_stat & irq_mask);

   //////////////////////////////////////////////////////////////////////////
   // Read data mux; rate register reads as zero

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (acc_rd) begin
         case (a_addr)
            reg_addr(`FRC_IDX_RATE_STAT): begin
               next_rdata[`FRC_RATE_MSB:`FRC_RATE_LSB] = rate;
               if (mode == frc_pkg::FRC_MODE_THIRD) begin
                  next_rdata[`FRC_PRECOMP_BIT] = precomp_off_flag;
               end
            end
            reg_addr(`FRC_IDX_DATA): begin
               if (phase == frc_pkg::FRC_PH_RESULT) begin
                  next_rdata[7:0] = res_ptr ? stat1 : stat0;
               end
            end
            reg_addr(`FRC_IDX_OUT_CTL):
               next_rdata[`FRC_CORE_RUN_BIT] = core_run;
            reg_addr(`FRC_IDX_MODE_CFG):
               next_rdata[`FRC_MODE_MSB:`FRC_MODE_LSB] = mode;
            reg_addr(`FRC_IDX_STAT0):
               next_rdata[7:0] = stat0;
            reg_addr(`FRC_IDX_STAT1):
               next_rdata[7:0] = stat1;
            reg_addr(`FRC_IDX_IRQ_STAT):
               next_rdata[`FRC_IRQ_W-1:0] = irq_stat;
            reg_addr(`FRC_IDX_IRQ_MASK):
               next_rdata[`FRC_IRQ_W-1:0] = irq_mask;
            default:
               next_rdata = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge MCLK_I)
      if (!RESET_N_I)
         HRDATA_O <= 32'h0000_0000;
      else if (acc_rd)
         HRDATA_O <= next_rdata;
   assign DENSITY_SELECT_PIN_O = density_select_pin;
   assign RATE_SELECT_O        = rate;
   assign CORE_RESET_O         = soft_rst;

endmodule
`default_nettype wire

// ---- sim/frc_engine_model.sv ----
// Command engine and drive pin model that feeds the block's far side
`default_nettype none
module frc_engine_model (
   // Clock
   input  wire logic           clk_i,
   // Command link and drive pins {track zero, index, protect, end}
   output frc_pkg::frc_start_t info_o,
   output logic                start_o,
   output logic                end_o,
   output logic [1:0]          code_o,
   output frc_pkg::frc_evt_t   evt_o,
   output logic [3:0]          pins_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {info_o, start_o, end_o, code_o, evt_o, pins_o} = '0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Start, n event pulses each driving pins pn (index bit pulsed, others held), then end
   task automatic run(input frc_pkg::frc_start_t inf, input logic [7:0] ev,
                      input logic [4:0] n, input logic [3:0] pn,
                      input logic [1:0] c);
      @(posedge clk_i);
      start_o <= 1'b1;
      info_o  <= inf;
      @(posedge clk_i);
      start_o <= 1'b0;
      repeat (n) begin
         evt_o  <= ev;
         pins_o <= pn;
         @(posedge clk_i);
         evt_o  <= '0;
         pins_o <= pn & 4'hB;
         @(posedge clk_i);
      end
      end_o  <= 1'b1;
      code_o <= c;
      @(posedge clk_i);
      end_o  <= 1'b0;
      pins_o <= '0;
   endtask
endmodule
`default_nettype wire

// ---- sim/frc_properties.sv ----
// Checker of bus answers and rate and density outputs
`default_nettype none
`include "frc_map.svh"
module frc_properties #(
   parameter int RECAL_STEPS = 80
) (
   input wire logic        MCLK_I,
   input wire logic        RESET_N_I,
   input wire logic        HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0]  HTRANS_I,
   input wire logic        HWRITE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic        HREADY_I,
   input wire logic [31:0] HRDATA_O,
   input wire logic        HREADYOUT_O,
   input wire logic        HRESP_O,
   input wire logic        DENSITY_SELECT_PIN_O,
   input wire logic [1:0]  RATE_SELECT_O
);
   default clocking @(posedge MCLK_I);
   endclocking
   default disable iff (!RESET_N_I);
   logic        rd;
   logic        wr;
   logic        wr_d;
   logic [13:0] a;
   logic [1:0]  wd;
   assign a  = HADDR_I[13:0];
   assign wd = HWDATA_I[1:0];
   assign wr = HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
   assign rd = HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I;
   always_ff @(posedge MCLK_I) begin
      wr_d <= RESET_N_I && wr;
   end
   ////////////////////////////////////////////////////////////////////////
   property p_rst;
      $rose(RESET_N_I) |-> DENSITY_SELECT_PIN_O && RATE_SELECT_O == 2'h2;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_wr;
      wr && a == `FRC_IDX_RATE_CFG * 4 |-> ##2 RATE_SELECT_O == $past(wd);
   endproperty
   a_wr: assert property (p_wr) else $error("rate write");
   property p_hold;
      RESET_N_I && !wr_d |=> $stable(RATE_SELECT_O);
   endproperty
   a_hold: assert property (p_hold) else $error("rate moved");
   property p_wo;
      rd && (a == `FRC_IDX_RATE_CFG * 4 || a == 14'h0) |=> HRDATA_O == '0;
   endproperty
   a_wo: assert property (p_wo) else $error("write only");
   property p_st0;
      rd && a == `FRC_IDX_STAT0 * 4 |=> !HRDATA_O[3] && HRDATA_O[31:8] == '0;
   endproperty
   a_st0: assert property (p_st0) else $error("status 0 bit");
   property p_st1;
      rd && a == `FRC_IDX_STAT1 * 4 |=> !HRDATA_O[6] && !HRDATA_O[3];
   endproperty
   a_st1: assert property (p_st1) else $error("status 1 bit");
   property p_rs;
      rd && !wr_d && a == `FRC_IDX_RATE_STAT * 4 |=>
         HRDATA_O[1:0] == RATE_SELECT_O;
   endproperty
   a_rs: assert property (p_rs) else $error("rate status");
   property p_resp;
      rd || wr |=> HREADYOUT_O && !HRESP_O;
   endproperty
   a_resp: assert property (p_resp) else $error("response");
   c_wr: cover property (wr && a == `FRC_IDX_RATE_CFG * 4);
   c_data: cover property (rd && a == `FRC_IDX_DATA * 4);
   c_rst: cover property ($rose(RESET_N_I));
endmodule
bind frc_top frc_properties #(.RECAL_STEPS(RECAL_STEPS)) frc_properties_inst (
   .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .HSEL_I(HSEL_I),
   .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
   .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
   .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
   .DENSITY_SELECT_PIN_O(DENSITY_SELECT_PIN_O),
   .RATE_SELECT_O(RATE_SELECT_O));
`default_nettype wire

// ---- sim/test_frc_top.sv ----
// Self-checking bench of the rate and result status block
`default_nettype none
`include "frc_map.svh"
`define CHK(nm, e, v) begin checks_done++; if ((v) !== (e)) begin \
   failures++; $display("[FAIL] %s exp %h got %h", nm, e, v); end end
module test_frc_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic                MCLK_I = 1'b0;
   logic                RESET_N_I = 1'b0;
   logic [31:0]         HADDR_I = '0;
   logic [1:0]          HTRANS_I = 2'h0;
   logic                HWRITE_I = 1'b0;
   logic [31:0]         HWDATA_I = '0;
   logic [31:0]         HRDATA_O;
   logic                HREADYOUT_O;
   logic                DENSITY_SELECT_PIN_O;
   logic [1:0]          RATE_SELECT_O;
   logic                IRQ_O;
   frc_pkg::frc_start_t info;
   frc_pkg::frc_evt_t   evt;
   logic                st;
   logic                en;
   logic [1:0]          code;
   logic [3:0]          pins;
   int                  failures = 0;
   int                  checks_done = 0;
   logic [31:0]         seed = 32'h620F46EF;
   // Case layout: cmd, events, pulses, pins, seek and fault, status 1
   logic [29:0]         tc [8] = '{
      {3'h1, 8'h00, 5'h0, 4'h0, 2'h2, 8'h00},
      {3'h2, 8'h02, 5'h1, 4'h0, 2'h3, 8'h00},
      {3'h3, 8'h01, 5'h5, 4'h0, 2'h3, 8'h00},
      {3'h4, 8'h70, 5'h1, 4'h0, 2'h0, 8'hB4},
      {3'h5, 8'h00, 5'h1, 4'h3, 2'h0, 8'h02},
      {3'h7, 8'h40, 5'h2, 4'h4, 2'h0, 8'h25},
      {3'h0, 8'h8C, 5'h1, 4'h0, 2'h0, 8'h85},
      {3'h6, 8'h00, 5'h1, 4'h1, 2'h0, 8'h00}};
   always #25 MCLK_I = ~MCLK_I;
   frc_engine_model frc_engine_model_inst (.clk_i(MCLK_I), .info_o(info),
      .start_o(st), .end_o(en), .code_o(code), .evt_o(evt), .pins_o(pins));
   frc_top #(.RECAL_STEPS(5)) frc_top_inst (.MCLK_I(MCLK_I),
      .RESET_N_I(RESET_N_I), .HSEL_I(1'b1), .HADDR_I(HADDR_I),
      .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(3'h2),
      .HWDATA_I(HWDATA_I), .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O),
      .HREADYOUT_O(HREADYOUT_O), .HRESP_O(), .CMD_START_I(st),
      .CMD_INFO_I(info), .CMD_END_I(en), .CMD_CODE_I(code), .EVT_I(evt),
      .TRACK_ZERO_PIN_I(pins[3]), .INDEX_PULSE_PIN_I(pins[2]),
      .WRITE_PROTECT_PIN_I(pins[1]), .TRANSFER_END_SIGNAL_I(pins[0]),
      .DENSITY_SELECT_PIN_O(DENSITY_SELECT_PIN_O),
      .RATE_SELECT_O(RATE_SELECT_O), .CORE_RESET_O(), .IRQ_O(IRQ_O));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic tally_and_finish();
      if (failures == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // One single transfer; read data taken at the edge ending data phase
   task automatic bus(input logic w, input logic [11:0] idx,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge MCLK_I);
      HTRANS_I <= 2'h2;
      HWRITE_I <= w;
      HADDR_I  <= {18'h0, idx, 2'h0};
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do begin
            @(posedge MCLK_I);
            n++;
         end while (HREADYOUT_O !== 1'b1 && n < 16);
         if (n >= 16) begin
            failures++;
            tally_and_finish();
         end
         if (p == 0) begin
            HTRANS_I <= 2'h0;
            HWDATA_I <= d;
         end
      end
      r = HRDATA_O;
      #1;
   endtask
   task automatic wr(input logic [11:0] idx, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, idx, d, r);
   endtask
   task automatic hw_reset();
      repeat (2) @(posedge MCLK_I);
      RESET_N_I <= 1'b1;
      @(posedge MCLK_I);
      #1;
      `CHK("rst", 4'h6, {IRQ_O, DENSITY_SELECT_PIN_O, RATE_SELECT_O})
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] v;
      logic [7:0]  ev;
      logic [4:0]  n;
      logic [3:0]  pn;
      logic [2:0]  c;
      logic [1:0]  sf;
      logic [7:0]  s1;
      logic [1:0]  rt;
      logic        dn;
      hw_reset();
      wr(`FRC_IDX_OUT_CTL, 32'h4);
      seed = xs(seed);
      for (int i = 0; i < 8; i++) begin
         rt = i[1:0] ^ seed[1:0];
         if (i == 4) wr(`FRC_IDX_MODE_CFG, 32'h8);
         wr(`FRC_IDX_RATE_CFG, {30'h0, rt});
         `CHK("rate", rt, RATE_SELECT_O)
         @(posedge MCLK_I);
         #1;
         `CHK("dens", 1'(rt[0] ^ rt[1] ^ (i < 4)), DENSITY_SELECT_PIN_O)
         bus(1'b0, `FRC_IDX_RATE_STAT, 32'h0, v);
         `CHK("rstat", rt, v[1:0])
      end
      wr(`FRC_IDX_MODE_CFG, 32'h0);
      wr(`FRC_IDX_RATE_CFG, 32'h5);
      bus(1'b0, `FRC_IDX_RATE_STAT, 32'h0, v);
      `CHK("prec", 3'h5, v[2:0])
      dn = DENSITY_SELECT_PIN_O;
      wr(`FRC_IDX_RATE_STAT, 32'h81);
      wr(`FRC_IDX_OUT_CTL, 32'h0);
      wr(`FRC_IDX_OUT_CTL, 32'h4);
      bus(1'b0, `FRC_IDX_RATE_STAT, 32'h0, v);
      `CHK("swrst", {dn, 3'h5}, {DENSITY_SELECT_PIN_O, v[2:0]})
      bus(1'b0, `FRC_IDX_RATE_CFG, 32'h0, v);
      `CHK("wo", 32'h0, v)
      bus(1'b0, 12'h0, 32'h0, v);
      `CHK("unmapped", 32'h0, v)
      for (int i = 0; i < 8; i++) begin
         {c, ev, n, pn, sf, s1} = tc[i];
         seed = xs(seed);
         frc_engine_model_inst.run({c, seed[2:0]}, ev, n, pn, i[1:0]);
         bus(1'b0, `FRC_IDX_DATA, 32'h0, v);
         `CHK("st0", {i[1:0], sf, 1'b0, seed[2:0]}, v[7:0])
         bus(1'b0, `FRC_IDX_DATA, 32'h0, v);
         `CHK("st1", s1, v[7:0])
         bus(1'b0, `FRC_IDX_DATA, 32'h0, v);
         `CHK("idle", 32'h0, v)
         if (i == 0) begin
            `CHK("irq", 1'b0, IRQ_O)
            wr(`FRC_IDX_IRQ_MASK, 32'h1);
            `CHK("irq", 1'b1, IRQ_O)
            wr(`FRC_IDX_IRQ_STAT, 32'h1);
            `CHK("irq", 1'b0, IRQ_O)
         end
      end
      @(posedge MCLK_I);
      RESET_N_I <= 1'b0;
      hw_reset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
